// >>> pkg/shifter_pkg.sv
// Purpose: shared constants and types of the three-wire serial shifter
// Assumes: one 20 MHz system clock; pins are synchronised inside the block
// Notes: control bits arrive as one packed struct from the owning logic
package shifter_pkg;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam int MSB_POS = 7;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_TIMER = 2'b01,
        SRC_SOFT = 2'b10,
        SRC_OFF = 2'b11
    } clk_src_e;

    typedef enum logic {
        WIRE_THREE = 1'b0,
        WIRE_TWO = 1'b1
    } wire_mode_e;

    // ****************************************
    // shift_control_register fields
    // ****************************************
    typedef struct packed {
        wire_mode_e wire_mode;
        clk_src_e clk_src;
        logic external_edge_select;
        logic data_out_enable;
        logic clock_pin_drive;
        logic start_irq_enable;
        logic overflow_hold_enable;
    } shift_control_s;

    // ****************************************
    // software strobes, one cycle each
    // ****************************************
    typedef struct packed {
        logic data_write;
        logic [7:0] data_value;
        logic count_write;
        logic [3:0] count_value;
        logic overflow_clear;
        logic start_clear;
        logic clock_strobe;
        logic clock_toggle_strobe;
    } shift_strobe_s;

endpackage

// >>> rtl/universal_serial_shifter_three_wire.sv
// Purpose: eight-bit serial shift port with edge counter and clock control
// Assumes: pins and the shift clock are asynchronous; system clock 20 MHz
// Notes: shift clock may run at most at a quarter of the system clock
//
// Functional notes
// - one 8-bit shift register, software read/write
// - buffer copy of shift register kept
// - msb routed to data-out or data pin
// - pin clock: output latch changes on opposite edge
// - serial input always from serial_in_pin
// - 4-bit counter, read/write, overflow flag
// - counter and shifter share one clock
// - external clock counts both edges
// - clock from pin, timer or strobe
// - start condition may raise interrupt
// - two-wire: hold clock low after start/overflow
// - three-wire acts as SPI mode 0/1
// - no hardware slave select
// - eight clocks exchange both registers
// - master clock by pin toggle strobe
// - edge select 0: sample rise, shift fall
// - edge select 1: sample fall, shift rise
// - output set up before first sample
// - sixteen edges overflow, flag byte done
// - overflow wakes processor from idle
// - data falls while clock high: start
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shifter_three_wire (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire shifter_pkg::shift_control_s i_ctrl,
    input wire shifter_pkg::shift_strobe_s i_strobe,
    input wire logic i_timer_match,
    input wire logic i_serial_in_pin,
    input wire logic i_shift_clock_pin,
    output logic o_shift_clock_out,
    output logic o_shift_clock_oe_b,
    output logic o_data_out,
    output logic o_data_out_oe_b,
    output logic o_serial_data_out,
    output logic o_serial_data_oe_b,
    output logic [7:0] o_serial_shift_register,
    output logic [7:0] o_serial_shift_copy_register,
    output logic [3:0] o_count,
    output logic o_counter_overflow_flag,
    output logic o_start_condition_flag,
    output logic o_start_irq,
    output logic o_overflow_wake
);
    import shifter_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYNC_STAGES-1:0] sck_sync_q;
    logic [SYNC_STAGES-1:0] din_sync_q;
    logic sck_prev_q;
    logic din_prev_q;
    logic sck_lvl;
    logic din_lvl;

    // two flops before any logic looks at a pin
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_sync_q <= '0;
            din_sync_q <= '0;
            sck_prev_q <= 1'b0;
            din_prev_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[0], i_shift_clock_pin};
            din_sync_q <= {din_sync_q[0], i_serial_in_pin};
            sck_prev_q <= sck_sync_q[1];
            din_prev_q <= din_sync_q[1];
        end
    end

    assign sck_lvl = sck_sync_q[1];
    assign din_lvl = din_sync_q[1];

    // ****************************************
    // clock selection
    // ****************************************
    logic sck_rise;
    logic sck_fall;
    logic ext_sel;
    logic sample_edge;
    logic shift_tick;
    logic count_tick;
    logic latch_open;

    assign sck_rise = sck_lvl & ~sck_prev_q;
    assign sck_fall = ~sck_lvl & sck_prev_q;
    assign ext_sel = (i_ctrl.clk_src == SRC_EXT);

    // the edge select picks the sampling edge; the output latch covers the driving edge
    always_comb begin
        sample_edge = 1'b0;
        count_tick = 1'b0;
        case (i_ctrl.clk_src)
            SRC_EXT: begin
                sample_edge = i_ctrl.external_edge_select ? sck_fall : sck_rise;
                count_tick = sck_rise | sck_fall;
            end
            SRC_TIMER: begin
                sample_edge = i_timer_match;
                count_tick = i_timer_match;
            end
            SRC_SOFT: begin
                sample_edge = i_strobe.clock_strobe;
                count_tick = i_strobe.clock_strobe;
            end
            default: begin
                sample_edge = 1'b0;
            end
        endcase
    end

    assign shift_tick = sample_edge;
    // latch is see-through while the clock rests on its driving phase
    assign latch_open = ext_sel ? (sck_lvl == i_ctrl.external_edge_select) : 1'b1;

    // ****************************************
    // shift register and buffer copy
    // ****************************************
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [7:0] copy_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic wrap;

    // software write wins over a shift landing in the same cycle
    always_comb begin
        shreg_d = shreg_q;
        if (i_strobe.data_write) begin
            shreg_d = i_strobe.data_value;
        end else if (shift_tick) begin
            shreg_d = {shreg_q[MSB_POS-1:0], din_lvl};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shreg_q <= DATA_RST;
        end else begin
            shreg_q <= shreg_d;
        end
    end

    // copy taken with the byte that completes, so software need not race
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            copy_q <= DATA_RST;
        end else if (wrap) begin
            copy_q <= shreg_d;
        end
    end

    // ****************************************
    // edge counter and overflow flag
    // ****************************************
    assign wrap = count_tick & ~i_strobe.count_write & (cnt_q == CNT_MAX);

    always_comb begin
        cnt_d = cnt_q;
        if (i_strobe.count_write) begin
            cnt_d = i_strobe.count_value;
        end else if (count_tick) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    logic ovf_q;

    // a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovf_q <= 1'b0;
        end else if (wrap) begin
            ovf_q <= 1'b1;
        end else if (i_strobe.overflow_clear) begin
            ovf_q <= 1'b0;
        end
    end

    // ****************************************
    // output latch and pin routing
    // ****************************************
    logic out_bit_q;
    logic do_q;
    logic do_oe_b_q;
    logic sda_oe_b_q;

    // holds the msb until the opposite edge so the peer samples clean data
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_bit_q <= 1'b0;
        end else if (latch_open) begin
            out_bit_q <= shreg_d[MSB_POS];
        end
    end

    // no select input: slave choice stays with software
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            do_q <= 1'b0;
            do_oe_b_q <= 1'b1;
            sda_oe_b_q <= 1'b1;
        end else begin
            do_q <= out_bit_q;
            do_oe_b_q <= ~(i_ctrl.data_out_enable & (i_ctrl.wire_mode == WIRE_THREE));
            sda_oe_b_q <= ~(i_ctrl.data_out_enable & (i_ctrl.wire_mode == WIRE_TWO)
                          & ~out_bit_q);
        end
    end

    // ****************************************
    // two-wire start detector and clock hold
    // ****************************************
    logic start_q;
    logic start_hold_q;
    logic start_seen;
    logic hold;

    assign start_seen = (i_ctrl.wire_mode == WIRE_TWO) & sck_lvl & sck_prev_q
                        & ~din_lvl & din_prev_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_q <= 1'b0;
        end else if (start_seen) begin
            start_q <= 1'b1;
        end else if (i_strobe.start_clear) begin
            start_q <= 1'b0;
        end
    end

    // clock is held only once the master has pulled it low after start
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_hold_q <= 1'b0;
        end else if (!start_q || start_seen) begin
            start_hold_q <= 1'b0;
        end else if (sck_fall) begin
            start_hold_q <= 1'b1;
        end
    end

    assign hold = (i_ctrl.wire_mode == WIRE_TWO)
                  & (start_hold_q | (i_ctrl.overflow_hold_enable & ovf_q));

    // ****************************************
    // master clock generation
    // ****************************************
    logic tog_q;
    logic sck_out_q;
    logic sck_oe_b_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tog_q <= 1'b0;
        end else if (i_strobe.clock_toggle_strobe) begin
            tog_q <= ~tog_q;
        end
    end

    // two-wire pin is open drain, so only a low level is ever driven
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_out_q <= 1'b0;
            sck_oe_b_q <= 1'b1;
        end else begin
            sck_out_q <= hold ? 1'b0 : tog_q;
            sck_oe_b_q <= ~(hold | (i_ctrl.clock_pin_drive
                          & ((i_ctrl.wire_mode == WIRE_THREE) | ~tog_q)));
        end
    end

    // ****************************************
    // event outputs
    // ****************************************
    logic start_irq_q;
    logic wake_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            start_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            start_irq_q <= (start_q | start_seen) & i_ctrl.start_irq_enable;
            wake_q <= ovf_q | wrap;
        end
    end

    assign o_shift_clock_out = sck_out_q;
    assign o_shift_clock_oe_b = sck_oe_b_q;
    assign o_data_out = do_q;
    assign o_data_out_oe_b = do_oe_b_q;
    assign o_serial_data_out = 1'b0 & do_q;
    assign o_serial_data_oe_b = sda_oe_b_q;
    assign o_serial_shift_register = shreg_q;
    assign o_serial_shift_copy_register = copy_q;
    assign o_count = cnt_q;
    assign o_counter_overflow_flag = ovf_q;
    assign o_start_condition_flag = start_q;
    assign o_start_irq = start_irq_q;
    assign o_overflow_wake = wake_q;

endmodule
`default_nettype wire

// >>> tb/shifter_checker_assertions.sv
// Purpose: port-level checks for the serial shifter
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to every shifter instance by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module shifter_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire shifter_pkg::shift_control_s i_ctrl,
    input wire shifter_pkg::shift_strobe_s i_strobe,
    input wire logic o_data_out_oe_b,
    input wire logic o_shift_clock_oe_b,
    input wire logic [7:0] o_serial_shift_register,
    input wire logic [7:0] o_serial_shift_copy_register,
    input wire logic [3:0] o_count,
    input wire logic o_counter_overflow_flag,
    input wire logic o_start_condition_flag,
    input wire logic o_overflow_wake
);
    import shifter_pkg::*;
    // ****
    // properties
    // ****
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // a tick from fifteen lands on zero and raises the flag at once
    property p_wrap;
        o_count == 4'h0 && $past(o_count) == 4'hF && !$past(i_strobe.count_write)
            |-> o_counter_overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap without flag");
    property p_hold;
        o_counter_overflow_flag && !i_strobe.overflow_clear |=> o_counter_overflow_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_wake;
        $rose(o_counter_overflow_flag) |-> o_overflow_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    // the copy must match what was shifted, so software can read it late
    property p_copy;
        $rose(o_counter_overflow_flag) |-> o_serial_shift_copy_register == o_serial_shift_register;
    endproperty
    a_copy: assert property (p_copy) else $error("copy stale");
    property p_dwr;
        i_strobe.data_write |=> o_serial_shift_register == $past(i_strobe.data_value);
    endproperty
    a_dwr: assert property (p_dwr) else $error("data write lost");
    property p_cwr;
        i_strobe.count_write |=> o_count == $past(i_strobe.count_value);
    endproperty
    a_cwr: assert property (p_cwr) else $error("count write lost");
    property p_off;
        i_ctrl.clk_src == SRC_OFF && !i_strobe.count_write |=> $stable(o_count);
    endproperty
    a_off: assert property (p_off) else $error("count moved with clock off");
    property p_oe;
        (i_ctrl.wire_mode == WIRE_THREE && i_ctrl.data_out_enable) [*2] |-> !o_data_out_oe_b;
    endproperty
    a_oe: assert property (p_oe) else $error("data out not driven");
    // ****
    // covers
    // ****
    c_ovf: cover property ($rose(o_counter_overflow_flag));
    c_start: cover property ($rose(o_start_condition_flag));
    c_hold: cover property (!o_shift_clock_oe_b && i_ctrl.wire_mode == WIRE_TWO);
endmodule
bind universal_serial_shifter_three_wire shifter_checker chk_i (.*);
`default_nettype wire

// >>> tb/spi_peer.sv
// Purpose: behavioural peer shift register on the far side of the link
// Assumes: the bench or the device makes the shift clock
// Notes: always driving; there is no hardware select
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
    input wire logic i_sclk,
    input wire logic i_mode,
    input wire logic i_mosi,
    input wire logic i_load,
    input wire logic [7:0] i_byte,
    output logic o_miso,
    output logic [7:0] o_byte
);
    // load shows the msb at once, so setup is long before the first sample
    always @(i_sclk or posedge i_load) begin
        if (i_load) begin
            o_byte = i_byte;
            o_miso = i_byte[7];
        end else if (i_sclk ^ i_mode) begin
            o_byte = {o_byte[6:0], i_mosi};
        end else begin
            o_miso = o_byte[7];
        end
    end
endmodule
`default_nettype wire

// >>> tb/universal_serial_shifter_three_wire_tb.sv
// Purpose: self-checking bench for the serial shifter
// Assumes: peer model on the far side, bench or device is clock master
// Notes: bench link clock 400 ns, split 120/280 so outputs settle before sampling; device toggle clock 600 ns
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shifter_three_wire_tb;
    import shifter_pkg::*;
    logic ck = 0;
    logic rst_b = 0;
    logic mclk = 0;
    logic tm = 0;
    logic ovr = 1;
    logic ovr_en = 0;
    logic pld = 0;
    logic [7:0] pb = 8'h00;
    shift_control_s ctrl = '0;
    shift_strobe_s strb = '0;
    wire logic sclk, din, mosi, miso, sco, sco_b, dout, dout_b, sdo, sdo_b, flg, sflg, irq, wake;
    wire logic [7:0] shreg, copy, pbyte;
    wire logic [3:0] cnt;
    int errors = 0;
    int compares = 0;
    always #25 ck = ~ck;
    // wired-and pins; a released data-out line shows the opposite level
    assign sclk = mclk & (sco_b | sco);
    assign din = (ovr_en ? ovr : miso) & (sdo_b | sdo);
    assign mosi = dout ^ dout_b;
    universal_serial_shifter_three_wire uut (.i_ref_clk(ck), .i_rst_b(rst_b), .i_ctrl(ctrl),
        .i_strobe(strb), .i_timer_match(tm), .i_serial_in_pin(din), .i_shift_clock_pin(sclk),
        .o_shift_clock_out(sco), .o_shift_clock_oe_b(sco_b), .o_data_out(dout),
        .o_data_out_oe_b(dout_b), .o_serial_data_out(sdo), .o_serial_data_oe_b(sdo_b),
        .o_serial_shift_register(shreg), .o_serial_shift_copy_register(copy), .o_count(cnt),
        .o_counter_overflow_flag(flg), .o_start_condition_flag(sflg), .o_start_irq(irq),
        .o_overflow_wake(wake));
    spi_peer peer (.i_sclk(sclk), .i_mode(ctrl.external_edge_select), .i_mosi(mosi),
        .i_load(pld), .i_byte(pb), .o_miso(miso), .o_byte(pbyte));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %0t: %s", $time, m);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one-cycle strobe, then room for the shifter and pins to settle
    task automatic fire(input shift_strobe_s s);
        @(negedge ck);
        strb = s;
        @(negedge ck);
        strb = '0;
        repeat (4) @(negedge ck);
    endtask
    task automatic tick;
        @(negedge ck);
        tm = 1'b1;
        @(negedge ck);
        tm = 1'b0;
        repeat (3) @(negedge ck);
    endtask
    task automatic xfer(input logic md, input logic [7:0] db, input logic [7:0] pv,
        input logic tog);
        ctrl.external_edge_select = md;
        ctrl.clock_pin_drive = tog;
        pb = pv;
        pld = 1'b1;
        fire({1'b1, db, 1'b1, 4'h0, 4'b1000});
        pld = 1'b0;
        mclk = tog;
        ctrl.data_out_enable = 1'b1;
        repeat (8) @(negedge ck);
        if (!md) chk({7'h00, dout}, {7'h00, db[7]}, "first bit");
        #7;
        for (int i = 0; i < 16; i++) begin
            if (tog) begin
                fire({14'h0000, 4'b0001});
            end else begin
                mclk = ~mclk;
                #((mclk == md) ? 280 : 120);
            end
        end
        for (int i = 0; i < 40 && flg !== 1'b1; i++) @(negedge ck);
        if (flg !== 1'b1) begin
            errors++;
            report_and_stop;
        end
        @(negedge ck);
        chk({4'h0, cnt}, 8'h00, "count");
        chk(shreg, pv, "received");
        chk(copy, pv, "copy");
        chk(pbyte, db, "sent");
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (3) @(negedge ck);
        rst_b = 1'b1;
        @(negedge ck);
        chk(shreg, 8'h00, "reset data");
        chk({3'b000, flg, cnt}, 8'h00, "reset count");
        $display("test reset done");
        xfer(1'b0, 8'hA5, 8'h3C, 1'b0);
        xfer(1'b1, 8'h5A, 8'hC3, 1'b1);
        $display("test exchange done");
        ctrl.clk_src = SRC_SOFT;
        fire({1'b0, 8'h00, 1'b1, 4'hE, 4'b1000});
        fire({14'h0000, 4'b0010});
        chk({3'b000, flg, cnt}, 8'h0F, "soft tick");
        ctrl.clk_src = SRC_TIMER;
        tick;
        chk({3'b000, flg, cnt}, 8'h10, "timer wrap");
        chk({7'h00, wake}, 8'h01, "wake");
        ctrl.clk_src = SRC_OFF;
        tick;
        fire({14'h0000, 4'b0010});
        chk({3'b000, flg, cnt}, 8'h10, "clock off");
        fire({14'h0000, 4'b1000});
        chk({7'h00, flg}, 8'h00, "clear");
        $display("test counter done");
        // two-wire: data falls under a high clock, then the clock is held
        ctrl = '0;
        ctrl.wire_mode = WIRE_TWO;
        ctrl.start_irq_enable = 1'b1;
        ovr_en = 1'b1;
        mclk = 1'b1;
        repeat (6) @(negedge ck);
        ovr = 1'b0;
        repeat (6) @(negedge ck);
        chk({6'h00, sflg, irq}, 8'h03, "start");
        mclk = 1'b0;
        repeat (6) @(negedge ck);
        mclk = 1'b1;
        repeat (6) @(negedge ck);
        chk({7'h00, sco_b}, 8'h00, "hold low");
        fire({14'h0000, 4'b0100});
        chk({6'h00, sflg, sco_b}, 8'h01, "released");
        // overflow hold: a soft tick from fifteen wraps and the clock is held low
        ctrl.overflow_hold_enable = 1'b1;
        ctrl.clk_src = SRC_SOFT;
        fire({1'b0, 8'h00, 1'b1, 4'hF, 4'b0000});
        fire({14'h0000, 4'b0010});
        chk({6'h00, flg, sco_b}, 8'h02, "overflow hold");
        fire({14'h0000, 4'b1000});
        chk({6'h00, flg, sco_b}, 8'h01, "hold freed");
        // a zero msb pulls the two-wire data pin, three-wire data out stays off
        ctrl.data_out_enable = 1'b1;
        fire({1'b1, 8'h00, 1'b0, 4'h0, 4'b0000});
        chk({5'h00, sdo, dout_b, sdo_b}, 8'h02, "data pin pulled");
        $display("test two-wire done");
        report_and_stop;
    end
    // a hang ends the run as a mismatch
    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
